// [hdl/scm_defs.vh]
// Constants for the system clock and operating-mode block.
// Assumes it is included by bare name into each module that needs it.
// Contract
// - The fast clock comes only from the built-in 8MHz RC oscillator with no pins of its own.
// - The slow clock comes from the 32.768kHz crystal or the 32kHz RC oscillator.
// - Slow source select 0 picks the RC oscillator, 1 the crystal, and it resets to 0.
// - In fast mode the system clock is the fast clock divided by 1 up to 64.
// - Selector codes 000 to 110 divide by 1,2,4,8,16,32,64, code 111 picks the slow clock.
// - Codes 000 to 110 mean fast mode, 111 slow mode, and the CPU runs in both.
// - Moving the system clock to the slow source leaves the fast oscillator to its enable bit.
// - In slow mode the fast clock follows its enable bit while the slow clock keeps running.
// - There are six modes: fast, slow, sleep and three idle modes with the CPU stopped.
// - Halt picks sleep, idle-slow, idle-both or idle-fast from the two halt-keep bits.
// - In sleep the slow RC clock runs only while the watchdog is enabled.
// - After the crystal is enabled its clock is unusable until a start-up delay passes.
// - The crystal stable flag clears on enable and rises only once the crystal is stable.
// - An unused crystal releases its two pins to the pin-sharing logic.
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

`define SCM_ADDR_W 2
`define SCM_DATA_W 8

`define SCM_OFF_SYSCTL 2'h0
`define SCM_OFF_FASTCTL 2'h1
`define SCM_OFF_XTALCTL 2'h2

`define SCM_BIT_SLOW_KEEP 0
`define SCM_BIT_FAST_KEEP 1
`define SCM_BIT_SRC_SEL 2
`define SCM_SEL_LSB 5
`define SCM_SEL_MSB 7
`define SCM_BIT_EN 0
`define SCM_BIT_STABLE 1

`define SCM_SEL_SLOW 3'h7
`define SCM_SEL_RST 3'h0
`define SCM_SRC_RC 1'h0
`define SCM_KEEP_RST 1'h0
`define SCM_FAST_EN_RST 1'h1
`define SCM_XTAL_EN_RST 1'h0

`define SCM_CNT_W 7
`define SCM_CNT_ONE 7'h01
`define SCM_RD_ZERO 8'h00

`endif

// [hdl/scm_sync.v]
// Two-flop synchroniser with change detect for one oscillator level.
// Assumes the oscillator is far slower than the sampling clock.
`timescale 1ns/1ps
`include "scm_defs.vh"

module scm_sync (
	input wire ref_clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire async_i,
	output wire level_o,
	output wire edge_o
);

reg meta_q;
reg sync_q;
reg last_q;

// First stage feeds only the second stage
always @(posedge ref_clk_i) begin
	if (rst_i) begin
		meta_q <= 1'b0;
		sync_q <= 1'b0;
		last_q <= 1'b0;
	end else if (ce_i) begin
		meta_q <= async_i;
		sync_q <= meta_q;
		last_q <= sync_q;
	end
end

assign level_o = sync_q;
// Either edge counts as one half period
assign edge_o = ce_i & (sync_q ^ last_q);

endmodule // scm_sync

// [hdl/scm_clock_mode.v]
// System clock selection, divider and operating-mode control.
// Assumes oscillator outputs arrive as async levels and halt, wake
// and watchdog enable come from logic on ref_clk_i.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "scm_defs.vh"

module scm_clock_mode #(
	parameter XTAL_START_EDGES = 1024,
	parameter FAST_START_EDGES = 16,
	parameter START_W = 11
) (
	input wire ref_clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire [`SCM_ADDR_W-1:0] reg_addr_i,
	input wire [`SCM_DATA_W-1:0] reg_wdata_i,
	input wire reg_we_i,
	input wire reg_re_i,
	input wire fast_rc_clk_i,
	input wire slow_rc_clk_i,
	input wire slow_crystal_clk_i,
	input wire halt_i,
	input wire wake_i,
	input wire wdt_enable_i,
	output reg [`SCM_DATA_W-1:0] reg_rdata_o,
	output reg system_clock_o,
	output reg fast_clock_o,
	output reg slow_clock_o,
	output reg slow_rc_clock_o,
	output reg fast_rc_osc_en_o,
	output reg slow_rc_osc_en_o,
	output reg slow_crystal_osc_en_o,
	output reg crystal_pins_release_o,
	output reg cpu_run_o,
	output reg [5:0] mode_o
);

////////////////////////////////////////////////////////////////////////
// Mode states

localparam [5:0] ST_FAST = 6'h01;
localparam [5:0] ST_SLOW = 6'h02;
localparam [5:0] ST_SLEEP = 6'h04;
localparam [5:0] ST_IDLE_SLOW = 6'h08;
localparam [5:0] ST_IDLE_BOTH = 6'h10;
localparam [5:0] ST_IDLE_FAST = 6'h20;

localparam [START_W-1:0] START_ONE = {{(START_W-1){1'b0}}, 1'b1};
localparam [START_W-1:0] XTAL_LIM = XTAL_START_EDGES[START_W-1:0] - START_ONE;
localparam [START_W-1:0] FAST_LIM = FAST_START_EDGES[START_W-1:0] - START_ONE;

////////////////////////////////////////////////////////////////////////
// Helpers

// Half periods of the source per system clock half period
function [`SCM_CNT_W-1:0] half_lim;
	input [2:0] sel;
	begin
		if (sel == `SCM_SEL_SLOW)
			half_lim = `SCM_CNT_ONE;
		else
			half_lim = `SCM_CNT_ONE << sel;
	end
endfunction

// Edge of the source named by a selector and slow source choice
function pick_edge;
	input [2:0] sel;
	input src;
	input fe;
	input re;
	input xe;
	begin
		if (sel != `SCM_SEL_SLOW)
			pick_edge = fe;
		else if (src == `SCM_SRC_RC)
			pick_edge = re;
		else
			pick_edge = xe;
	end
endfunction

// Running state chosen by the selector
function [5:0] run_state;
	input [2:0] sel;
	begin
		if (sel == `SCM_SEL_SLOW)
			run_state = ST_SLOW;
		else
			run_state = ST_FAST;
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Oscillator inputs

wire fast_lvl;
wire fast_edge;
wire rc_lvl;
wire rc_edge;
wire xtal_lvl;
wire xtal_edge;

scm_sync u_sync_fast (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.async_i(fast_rc_clk_i),
	.level_o(fast_lvl),
	.edge_o(fast_edge)
);

scm_sync u_sync_rc (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.async_i(slow_rc_clk_i),
	.level_o(rc_lvl),
	.edge_o(rc_edge)
);

scm_sync u_sync_xtal (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.async_i(slow_crystal_clk_i),
	.level_o(xtal_lvl),
	.edge_o(xtal_edge)
);

////////////////////////////////////////////////////////////////////////
// Control bits

reg [2:0] sel_q;
reg src_sel_q;
reg fast_keep_q;
reg slow_keep_q;
reg fast_en_q;
reg xtal_en_q;

wire wr_sys = reg_we_i && (reg_addr_i == `SCM_OFF_SYSCTL);
wire wr_fast = reg_we_i && (reg_addr_i == `SCM_OFF_FASTCTL);
wire wr_xtal = reg_we_i && (reg_addr_i == `SCM_OFF_XTALCTL);

always @(posedge ref_clk_i) begin
	if (rst_i) begin
		sel_q <= `SCM_SEL_RST;
		src_sel_q <= `SCM_SRC_RC;
		fast_keep_q <= `SCM_KEEP_RST;
		slow_keep_q <= `SCM_KEEP_RST;
		fast_en_q <= `SCM_FAST_EN_RST;
		xtal_en_q <= `SCM_XTAL_EN_RST;
	end else if (ce_i) begin
		if (wr_sys) begin
			sel_q <= reg_wdata_i[`SCM_SEL_MSB:`SCM_SEL_LSB];
			src_sel_q <= reg_wdata_i[`SCM_BIT_SRC_SEL];
			fast_keep_q <= reg_wdata_i[`SCM_BIT_FAST_KEEP];
			slow_keep_q <= reg_wdata_i[`SCM_BIT_SLOW_KEEP];
		end
		if (wr_fast)
			fast_en_q <= reg_wdata_i[`SCM_BIT_EN];
		if (wr_xtal)
			xtal_en_q <= reg_wdata_i[`SCM_BIT_EN];
	end
end

////////////////////////////////////////////////////////////////////////
// Operating mode

reg [5:0] state_q;
reg [5:0] state_d;

always @* begin
	state_d = state_q;
	case (state_q)
		ST_FAST, ST_SLOW: begin
			if (halt_i) begin
				case ({fast_keep_q, slow_keep_q})
					2'b00: state_d = ST_SLEEP;
					2'b01: state_d = ST_IDLE_SLOW;
					2'b11: state_d = ST_IDLE_BOTH;
					default: state_d = ST_IDLE_FAST;
				endcase
			end else begin
				state_d = run_state(sel_q);
			end
		end
		ST_SLEEP, ST_IDLE_SLOW, ST_IDLE_BOTH, ST_IDLE_FAST: begin
			if (wake_i)
				state_d = run_state(sel_q);
		end
		default: state_d = ST_FAST;
	endcase
end

// Which oscillators the present mode keeps alive
reg fast_on;
reg slow_on;
reg rc_on;

always @* begin
	fast_on = 1'b0;
	slow_on = 1'b0;
	rc_on = 1'b1;
	case (state_q)
		ST_FAST: begin
			fast_on = 1'b1;
			slow_on = 1'b1;
		end
		ST_SLOW: begin
			fast_on = fast_en_q;
			slow_on = 1'b1;
		end
		ST_IDLE_SLOW: slow_on = 1'b1;
		ST_IDLE_BOTH: begin
			fast_on = 1'b1;
			slow_on = 1'b1;
		end
		ST_IDLE_FAST: fast_on = 1'b1;
		ST_SLEEP: rc_on = wdt_enable_i;
		default: rc_on = 1'b1;
	endcase
end

////////////////////////////////////////////////////////////////////////
// Start-up tracking

reg [START_W-1:0] xtal_cnt_q;
reg xtal_ok_q;
reg [START_W-1:0] fast_cnt_q;
reg fast_ok_q;

// Crystal counts its own edges after enable; flag held low meanwhile
always @(posedge ref_clk_i) begin
	if (rst_i) begin
		xtal_cnt_q <= {START_W{1'b0}};
		xtal_ok_q <= 1'b0;
	end else if (ce_i) begin
		if (!xtal_en_q) begin
			xtal_cnt_q <= {START_W{1'b0}};
			xtal_ok_q <= 1'b0;
		end else if (!xtal_ok_q && xtal_edge) begin
			xtal_cnt_q <= xtal_cnt_q + START_ONE;
			xtal_ok_q <= (xtal_cnt_q == XTAL_LIM);
		end
	end
end

always @(posedge ref_clk_i) begin
	if (rst_i) begin
		fast_cnt_q <= {START_W{1'b0}};
		fast_ok_q <= 1'b0;
	end else if (ce_i) begin
		if (!fast_on) begin
			fast_cnt_q <= {START_W{1'b0}};
			fast_ok_q <= 1'b0;
		end else if (!fast_ok_q && fast_edge) begin
			fast_cnt_q <= fast_cnt_q + START_ONE;
			fast_ok_q <= (fast_cnt_q == FAST_LIM);
		end
	end
end

// Crystal only usable once stable
wire xtal_use = xtal_en_q & xtal_ok_q;
wire slow_lvl = (src_sel_q == `SCM_SRC_RC) ? rc_lvl : (xtal_lvl & xtal_use);
wire xtal_edge_ok = xtal_edge & xtal_use;

////////////////////////////////////////////////////////////////////////
// System clock generator

reg [2:0] act_sel_q;
reg act_src_q;
reg [`SCM_CNT_W-1:0] half_cnt_q;

wire req_edge = pick_edge(sel_q, src_sel_q, fast_edge, rc_edge, xtal_edge_ok);
wire act_edge = pick_edge(act_sel_q, act_src_q, fast_edge, rc_edge, xtal_edge_ok);
wire act_slow = (act_sel_q == `SCM_SEL_SLOW);
wire act_on = act_slow ? slow_on : fast_on;
wire pending = (sel_q != act_sel_q) ||
	((sel_q == `SCM_SEL_SLOW) && (src_sel_q != act_src_q));
wire [`SCM_CNT_W-1:0] cnt_next = half_cnt_q + `SCM_CNT_ONE;

// Switch only while low and on the new source's edge, so the first
// high phase is a full half period of the new source
always @(posedge ref_clk_i) begin
	if (rst_i) begin
		act_sel_q <= `SCM_SEL_RST;
		act_src_q <= `SCM_SRC_RC;
		half_cnt_q <= {`SCM_CNT_W{1'b0}};
		system_clock_o <= 1'b0;
	end else if (ce_i) begin
		if (pending && !system_clock_o && req_edge) begin
			act_sel_q <= sel_q;
			act_src_q <= src_sel_q;
			half_cnt_q <= {`SCM_CNT_W{1'b0}};
		end else if (act_edge && (act_on || system_clock_o)) begin
			// A stopping source finishes its high phase first
			if (cnt_next == half_lim(act_sel_q)) begin
				half_cnt_q <= {`SCM_CNT_W{1'b0}};
				system_clock_o <= ~system_clock_o;
			end else begin
				half_cnt_q <= cnt_next;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Peripheral clocks, enables and mode outputs

always @(posedge ref_clk_i) begin
	if (rst_i) begin
		fast_clock_o <= 1'b0;
		slow_clock_o <= 1'b0;
		slow_rc_clock_o <= 1'b0;
		fast_rc_osc_en_o <= 1'b0;
		slow_rc_osc_en_o <= 1'b0;
		slow_crystal_osc_en_o <= 1'b0;
		crystal_pins_release_o <= 1'b1;
		cpu_run_o <= 1'b0;
		mode_o <= ST_FAST;
		state_q <= ST_FAST;
	end else if (ce_i) begin
		state_q <= state_d;
		mode_o <= state_d;
		cpu_run_o <= state_d[0] | state_d[1];
		fast_clock_o <= fast_lvl & fast_on;
		slow_clock_o <= slow_lvl & slow_on;
		slow_rc_clock_o <= rc_lvl & rc_on;
		fast_rc_osc_en_o <= fast_on;
		slow_rc_osc_en_o <= rc_on;
		slow_crystal_osc_en_o <= xtal_en_q;
		crystal_pins_release_o <= ~xtal_en_q;
	end
end

////////////////////////////////////////////////////////////////////////
// Register read port

always @(posedge ref_clk_i) begin
	if (rst_i) begin
		reg_rdata_o <= `SCM_RD_ZERO;
	end else if (ce_i) begin
		reg_rdata_o <= `SCM_RD_ZERO;
		if (reg_re_i) begin
			case (reg_addr_i)
				`SCM_OFF_SYSCTL: begin
					reg_rdata_o[`SCM_SEL_MSB:`SCM_SEL_LSB] <= sel_q;
					reg_rdata_o[`SCM_BIT_SRC_SEL] <= src_sel_q;
					reg_rdata_o[`SCM_BIT_FAST_KEEP] <= fast_keep_q;
					reg_rdata_o[`SCM_BIT_SLOW_KEEP] <= slow_keep_q;
				end
				`SCM_OFF_FASTCTL: begin
					reg_rdata_o[`SCM_BIT_EN] <= fast_en_q;
					reg_rdata_o[`SCM_BIT_STABLE] <= fast_ok_q;
				end
				`SCM_OFF_XTALCTL: begin
					reg_rdata_o[`SCM_BIT_EN] <= xtal_en_q;
					reg_rdata_o[`SCM_BIT_STABLE] <= xtal_ok_q;
				end
				default: reg_rdata_o <= `SCM_RD_ZERO;
			endcase
		end
	end
end

endmodule // scm_clock_mode

// [tb/scm_checker.sv]
// Port-level assertions for scm_clock_mode.
// Assumes it is bound to the top module; everything is on ref_clk_i.
`timescale 1ns/1ps
module scm_checker (
	input wire ref_clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire halt_i,
	input wire wake_i,
	input wire wdt_enable_i,
	input wire system_clock_o,
	input wire fast_clock_o,
	input wire slow_clock_o,
	input wire slow_rc_clock_o,
	input wire fast_rc_osc_en_o,
	input wire slow_crystal_osc_en_o,
	input wire crystal_pins_release_o,
	input wire cpu_run_o,
	input wire [5:0] mode_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////
	a_pins_release: assert property (crystal_pins_release_o == !slow_crystal_osc_en_o)
		else $error("pin release disagrees with crystal enable");
	a_mode_onehot: assert property ($onehot(mode_o))
		else $error("mode is not one-hot");
	// First edge after reset still shows the reset value
	a_cpu_mode: assert property (!$past(rst_i) |-> cpu_run_o == |mode_o[1:0])
		else $error("cpu run disagrees with mode");
	a_halt_stops: assert property (|mode_o[1:0] && halt_i && ce_i |=> !cpu_run_o)
		else $error("halt did not stop the cpu");
	a_wake_runs: assert property (|mode_o[5:2] && wake_i && ce_i |=> cpu_run_o)
		else $error("wake did not restart the cpu");
	a_sleep_rc_off: assert property ((mode_o[2] && !wdt_enable_i) [*3] |-> !slow_rc_clock_o)
		else $error("slow rc clock runs in sleep without watchdog");
	a_sleep_clk_off: assert property (mode_o[2] [*3] |-> !fast_clock_o && !slow_clock_o)
		else $error("clock present in sleep");
	a_fast_osc_on: assert property (mode_o[0] [*3] |-> fast_rc_osc_en_o)
		else $error("fast oscillator off in fast mode");
	// Fastest source half period is several reference cycles
	a_no_runt: assert property ($changed(system_clock_o) |=> $stable(system_clock_o) [*3])
		else $error("runt phase on system clock");
endmodule // scm_checker
////////////////////////////////
bind scm_clock_mode scm_checker i_scm_checker (.ref_clk_i, .rst_i, .ce_i, .halt_i, .wake_i,
	.wdt_enable_i, .system_clock_o, .fast_clock_o, .slow_clock_o, .slow_rc_clock_o, .fast_rc_osc_en_o,
	.slow_crystal_osc_en_o, .crystal_pins_release_o, .cpu_run_o, .mode_o);

// [tb/tb_top.sv]
// Self-checking bench for scm_clock_mode.
// Assumes one 250MHz clock; oscillators are free-running levels off the clock grid.
`timescale 1ns/1ps
`include "scm_defs.vh"
module tb_top;
	logic ref_clk_i = 0, rst_i = 1, ce_i = 1, reg_we_i = 0, reg_re_i = 0;
	logic [1:0] reg_addr_i = 0;
	logic [7:0] reg_wdata_i = 0, reg_rdata_o;
	logic fast_rc_clk_i = 0, slow_rc_clk_i = 0, slow_crystal_clk_i = 0;
	logic halt_i = 0, wake_i = 0, wdt_enable_i = 0;
	logic system_clock_o, fast_clock_o, slow_clock_o, slow_rc_clock_o, cpu_run_o;
	logic fast_rc_osc_en_o, slow_rc_osc_en_o, slow_crystal_osc_en_o, crystal_pins_release_o;
	logic [5:0] mode_o;
	logic [5:0] halt_mode [4] = '{6'h04, 6'h08, 6'h20, 6'h10};
	int num_errors = 0, checks_done = 0;
	scm_clock_mode #(.XTAL_START_EDGES(4), .FAST_START_EDGES(2)) i_scm_clock_mode (.ref_clk_i,
		.rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .fast_rc_clk_i,
		.slow_rc_clk_i, .slow_crystal_clk_i, .halt_i, .wake_i, .wdt_enable_i, .reg_rdata_o,
		.system_clock_o, .fast_clock_o, .slow_clock_o, .slow_rc_clock_o, .fast_rc_osc_en_o,
		.slow_rc_osc_en_o, .slow_crystal_osc_en_o, .crystal_pins_release_o, .cpu_run_o, .mode_o);
	////////////////////////////////
	// Periods 10, 50 and 65 clock cycles
	initial forever #2 ref_clk_i = ~ref_clk_i;
	initial begin
		#1;
		forever #20 fast_rc_clk_i = ~fast_rc_clk_i;
	end
	initial begin
		#3;
		forever #100 slow_rc_clk_i = ~slow_rc_clk_i;
	end
	initial begin
		#5;
		forever #130 slow_crystal_clk_i = ~slow_crystal_clk_i;
	end
	////////////////////////////////
	task automatic give_verdict;
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, e, input string w);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, w, g, e);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1;
		@(posedge ref_clk_i) reg_we_i <= 0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		reg_addr_i <= a;
		reg_re_i <= 1;
		@(posedge ref_clk_i) reg_re_i <= 0;
		@(posedge ref_clk_i) d = reg_rdata_o;
	endtask
	task automatic rc(input logic [1:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e, "register read");
	endtask
	// Cycles from one system clock rise to the next
	task automatic rise(output int n);
		logic p;
		n = 0;
		p = 1;
		while (!(p === 0 && system_clock_o === 1) && n < 2000) begin
			p = system_clock_o;
			@(posedge ref_clk_i);
			n++;
		end
		if (n >= 2000) begin
			num_errors++;
			give_verdict();
		end
	endtask
	// One-cycle halt (w=0) or wake (w=1) pulse on the bench's own signals
	task automatic pulse(input bit w);
		if (w)
			wake_i <= 1;
		else
			halt_i <= 1;
		@(posedge ref_clk_i);
		halt_i <= 0;
		wake_i <= 0;
		repeat (2) @(posedge ref_clk_i);
	endtask
	////////////////////////////////
	initial begin
		int n, j;
		logic [2:0] s;
		logic [7:0] d;
		logic hi;
		void'($urandom(34));
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 0;
		repeat (20) @(posedge ref_clk_i);
		chk({cpu_run_o, mode_o, fast_rc_osc_en_o, slow_rc_osc_en_o, slow_crystal_osc_en_o,
			crystal_pins_release_o}, {1'b1, 6'h01, 4'b1101}, "reset state");
		rc(0, 8'h00);
		rc(1, 8'h03);
		rc(2, 8'h00);
		wr(3, 8'($urandom));
		rc(3, 8'h00);
		rc(0, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wr(0, {k[2:0], 5'h00});
			rc(0, {k[2:0], 5'h00});
			rise(n);
			rise(n);
			rise(n);
			chk(n, k == 7 ? 50 : 10 << k, "period");
			chk({cpu_run_o, mode_o}, {1'b1, k == 7 ? 6'h02 : 6'h01}, "run mode");
		end
		for (int k = 0; k < 4; k++) begin
			s = 3'($urandom_range(0, 6));
			wr(0, {s, 3'h0, k[1:0]});
			repeat (2) @(posedge ref_clk_i);
			pulse(0);
			chk({cpu_run_o, mode_o}, {1'b0, halt_mode[k]}, "halt mode");
			for (int w = 0; w < 2 && k == 0; w++) begin
				wdt_enable_i <= w[0];
				hi = 0;
				repeat (120) @(posedge ref_clk_i) hi |= slow_rc_clock_o;
				chk(hi, w, "rc clock in sleep");
				chk(slow_rc_osc_en_o, w, "rc osc enable in sleep");
			end
			pulse(1);
			chk({cpu_run_o, mode_o}, {1'b1, 6'h01}, "wake mode");
		end
		wr(2, 8'h01);
		rc(2, 8'h01);
		chk(crystal_pins_release_o, 0, "pins kept");
		j = 0;
		d = 0;
		while (d !== 8'h03 && j++ < 100)
			rd(2, d);
		chk(d, 8'h03, "crystal stable");
		wr(0, 8'he4);
		rise(n);
		rise(n);
		rise(n);
		chk(n, 65, "crystal period");
		for (int f = 0; f < 2; f++) begin
			wr(1, 8'(f));
			// Let the gated clock output see the new enable first
			repeat (2) @(posedge ref_clk_i);
			hi = 0;
			repeat (60) @(posedge ref_clk_i) hi |= fast_clock_o;
			chk(hi, f, "fast clock in slow");
			chk(fast_rc_osc_en_o, f, "fast osc enable");
		end
		give_verdict();
	end
endmodule // tb_top
